// ### design/spfe_link_if.sv
`timescale 1ns/1ps
interface spfe_link_if (
   input wire logic clk
);
   // Platform to powertrain
   logic pf_valid;
   logic [31:0] pf_hdr;
   logic [15:0] pf_data;
   // Powertrain to platform
   logic pt_valid;
   logic [31:0] pt_hdr;
   logic [15:0] pt_data;

   modport pt_end (
      input pf_valid, pf_hdr, pf_data,
      output pt_valid, pt_hdr, pt_data
   );
   modport pf_end (
      input pt_valid, pt_hdr, pt_data,
      output pf_valid, pf_hdr, pf_data
   );
endinterface : spfe_link_if

// ### design/spfe_pf_end.sv
`timescale 1ns/1ps
module spfe_pf_end #(
   parameter int LOOP_CYC = spfe_pkg::LOOP_CYCLES,
   parameter int SOH_LOOPS = spfe_pkg::SOH_LOOPS,
   parameter logic [7:0] PF_SRC = spfe_pkg::PF_SRC_DEFAULT
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link
   spfe_link_if.pf_end lk,
   // Vehicle state and password
   input wire logic [1:0] power_mode,
   input wire logic [15:0] password,
   // Results
   output logic fuel_continue_seen,
   output logic [7:0] status_byte,
   output logic status_strobe,
   output logic telltale
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (LOOP_CYC < 4) begin : g_bad_loop
      $error("LOOP_CYC too small");
   end
   if (SOH_LOOPS < 1 || SOH_LOOPS > 255) begin : g_bad_soh
      $error("SOH_LOOPS out of range");
   end

   localparam int CW = $clog2(LOOP_CYC);

   logic [CW-1:0] loop_cnt_ff;
   wire tick = (loop_cnt_ff == CW'(LOOP_CYC - 1));
   wire mode_en = (power_mode != spfe_pkg::MODE_OFF);
   wire rx_st = lk.pt_valid && mode_en && spfe_pkg::spfe_hdr_match(lk.pt_hdr, spfe_pkg::ST_RPT_HDR); // R2
   wire rx_req = lk.pt_valid && mode_en && spfe_pkg::spfe_hdr_match(lk.pt_hdr, spfe_pkg::PW_REQ_HDR); // R2

   logic seen_ff;
   logic [7:0] st_ff;
   logic strobe_ff;
   logic pw_pend_ff;
   logic ack_pend_ff;
   logic [7:0] miss_cnt_ff;
   logic tx_valid_ff;
   logic [31:0] tx_hdr_ff;
   logic [15:0] tx_data_ff;

   // Acknowledge first; password waits one cycle at most
   wire send_ack = ack_pend_ff && mode_en; // R12
   wire send_pw = pw_pend_ff && mode_en && !send_ack; // R1 R14
   wire miss_hit = (miss_cnt_ff >= 8'(SOH_LOOPS));

   // ----------------------------------------
   // Loop, receive and schedule
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_cnt_ff <= '0;
         seen_ff <= 1'b0;
         st_ff <= spfe_pkg::ST_RESET;
         strobe_ff <= 1'b0;
         pw_pend_ff <= 1'b0;
         ack_pend_ff <= 1'b0;
         miss_cnt_ff <= 8'h00;
      end else begin
         loop_cnt_ff <= tick ? '0 : loop_cnt_ff + 1'b1;
         strobe_ff <= rx_st;
         if (rx_st) begin
            st_ff <= lk.pt_data[7:0];
            seen_ff <= lk.pt_data[spfe_pkg::ST_FUEL_CONT]; // R1
         end else if (!mode_en) begin
            seen_ff <= 1'b0;
         end
         ack_pend_ff <= rx_st || (ack_pend_ff && !send_ack && mode_en); // R12
         pw_pend_ff <= (tick && mode_en && !seen_ff) || rx_req || (pw_pend_ff && !send_pw && mode_en); // R1 R14
         if (rx_st || !mode_en) begin
            miss_cnt_ff <= 8'h00;
         end else if (tick && !miss_hit) begin
            miss_cnt_ff <= miss_cnt_ff + 8'h01; // R16
         end
      end
   end

   // ----------------------------------------
   // Link output registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_valid_ff <= 1'b0;
         tx_hdr_ff <= 32'h0000_0000;
         tx_data_ff <= 16'h0000;
      end else begin
         tx_valid_ff <= send_ack || send_pw;
         if (send_ack) begin
            tx_hdr_ff <= {spfe_pkg::ST_ACK_HDR[31:16], PF_SRC, spfe_pkg::ST_ACK_HDR[7:0]};
            tx_data_ff <= 16'h0000;
         end else if (send_pw) begin
            tx_hdr_ff <= {spfe_pkg::PW_RPT_HDR[31:16], PF_SRC, spfe_pkg::PW_RPT_HDR[7:0]};
            tx_data_ff <= password;
         end
      end
   end

   assign lk.pf_valid = tx_valid_ff;
   assign lk.pf_hdr = tx_hdr_ff;
   assign lk.pf_data = tx_data_ff;
   assign fuel_continue_seen = seen_ff;
   assign status_byte = st_ff;
   assign status_strobe = strobe_ff;
   assign telltale = miss_hit; // R16

endmodule : spfe_pf_end

// ### design/spfe_pkg.sv
package spfe_pkg;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int LOOP_MS = 50;
   localparam int LOOP_CYCLES = LOOP_MS * (CLK_HZ / 1000);
   localparam int SOH_LOOPS = 10;

   // ----------------------------------------
   // Message headers (byte 1 is the source)
   // ----------------------------------------
   localparam logic [31:0] PW_REQ_HDR = 32'h4992_1001;
   localparam logic [31:0] PW_RPT_HDR = 32'h2893_0001;
   localparam logic [31:0] ST_RPT_HDR = 32'h2893_1002;
   localparam logic [31:0] ST_ACK_HDR = 32'h4992_0042;
   localparam logic [7:0] PF_SRC_DEFAULT = 8'h20;

   // ----------------------------------------
   // Status byte layout
   // ----------------------------------------
   localparam int ST_FUEL_CONT = 0;
   localparam int ST_DIS_TIMEOUT = 1;
   localparam int ST_DIS_IGN_OFF = 2;
   localparam int ST_AUTO_LEARN = 3;
   localparam int ST_FAIL_ENABLE = 4;
   localparam int ST_LEARN_EN = 5;
   localparam logic [7:0] ST_RESET = 8'h00;
   localparam logic [15:0] PW_RESET = 16'h0000;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [1:0] {
      MODE_OFF = 2'b00,
      MODE_ACC = 2'b01,
      MODE_RUN = 2'b10,
      MODE_CRANK = 2'b11
   } spfe_mode_e;

   typedef enum logic [1:0] {
      SEC_UNMATCHED = 2'b00,
      SEC_MATCHED = 2'b01,
      SEC_FAIL_EN = 2'b10
   } spfe_sec_e;

   // Even top nibble, then bits 27:16 and byte 0; bits 31:29 and the source byte are ignored
   function automatic logic spfe_hdr_match(input logic [31:0] hdr, input logic [31:0] pat);
      spfe_hdr_match = !hdr[28] && (hdr[27:16] == pat[27:16]) && (hdr[7:0] == pat[7:0]);
   endfunction : spfe_hdr_match

endpackage : spfe_pkg

// ### design/spfe_pt_end.sv
// What this block and spfe_pf_end do
// R1 - Platform sends password every 50 ms until fuel-continue
// R2 - Accept only headers with even top nibble
// R3 - Compare received password with learned password
// R4 - Password is plain 16-bit unsigned value
// R5 - Send status when it changes, enabled modes
// R6 - Send status after every accepted password
// R7 - Password health failure while running: fail-enable
// R8 - Status is one byte, bits 7-6 reserved
// R9 - Bit 0 set when correct password enables fuel
// R10 - Bits 5,4,3: learning, fail-enable, auto-learn timer
// R11 - Bits 2,1: disabled until ign off, timeout
// R12 - Acknowledge stops status retries
// R13 - Act on acknowledge only in Run, Crank
// R14 - Powertrain may request password; platform answers
// R15 - Status evaluated on 50 ms loop
// R16 - Platform flags lost status with a telltale
// R17 - Platform stays awake whenever powertrain is (no wake or sleep logic is modelled in either end)
// R18 - Until valid password, treat as unmatched
`timescale 1ns/1ps
module spfe_pt_end #(
   parameter int LOOP_CYC = spfe_pkg::LOOP_CYCLES,
   parameter int SOH_LOOPS = spfe_pkg::SOH_LOOPS
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Link
   spfe_link_if.pt_end lk,
   // Vehicle state
   input wire logic [1:0] power_mode,
   input wire logic engine_running,
   // Learned password and security inputs
   input wire logic [15:0] learned_pw,
   input wire logic learn_enable,
   input wire logic auto_learn_active,
   input wire logic fuel_dis_ign_off,
   input wire logic fuel_dis_timeout,
   // Results
   output logic fuel_enable,
   output logic [7:0] status_byte,
   output logic soh_fail
);

   // ----------------------------------------
   // Parameter checks
   // ----------------------------------------
   if (LOOP_CYC < 4) begin : g_bad_loop
      $error("LOOP_CYC too small");
   end
   if (SOH_LOOPS < 1 || SOH_LOOPS > 255) begin : g_bad_soh
      $error("SOH_LOOPS out of range");
   end

   localparam int CW = $clog2(LOOP_CYC);

   // ----------------------------------------
   // Application loop tick
   // ----------------------------------------
   logic [CW-1:0] loop_cnt_ff;
   logic [CW-1:0] nxt_loop_cnt;
   logic tick;
   logic tick_d_ff;

   assign tick = (loop_cnt_ff == CW'(LOOP_CYC - 1));
   assign nxt_loop_cnt = tick ? '0 : loop_cnt_ff + 1'b1;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         loop_cnt_ff <= '0;
         tick_d_ff <= 1'b0;
      end else begin
         loop_cnt_ff <= nxt_loop_cnt; // R15
         tick_d_ff <= tick;
      end
   end

   // ----------------------------------------
   // Mode and receive decode
   // ----------------------------------------
   wire mode_en = (power_mode != spfe_pkg::MODE_OFF);
   wire ack_mode = (power_mode == spfe_pkg::MODE_RUN) || (power_mode == spfe_pkg::MODE_CRANK);
   wire is_pw = spfe_pkg::spfe_hdr_match(lk.pf_hdr, spfe_pkg::PW_RPT_HDR); // R2
   wire is_ack = spfe_pkg::spfe_hdr_match(lk.pf_hdr, spfe_pkg::ST_ACK_HDR); // R2
   wire rx_pw = lk.pf_valid && is_pw && mode_en;
   wire rx_ack = lk.pf_valid && is_ack && ack_mode; // R13
   // Unsigned 16-bit equality, no scaling
   wire pw_ok = (lk.pf_data == learned_pw); // R3 R4

   // ----------------------------------------
   // Password health: loops without a password
   // ----------------------------------------
   logic [7:0] miss_cnt_ff;
   logic [7:0] nxt_miss_cnt;
   wire soh_hit = (miss_cnt_ff >= 8'(SOH_LOOPS));

   assign nxt_miss_cnt = (rx_pw || !mode_en) ? 8'h00 :
                         (tick && !soh_hit) ? miss_cnt_ff + 8'h01 : miss_cnt_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         miss_cnt_ff <= 8'h00;
      end else begin
         miss_cnt_ff <= nxt_miss_cnt;
      end
   end

   // ----------------------------------------
   // Security state
   // ----------------------------------------
   spfe_pkg::spfe_sec_e sec_ff;
   spfe_pkg::spfe_sec_e nxt_sec;

   always_comb begin
      nxt_sec = sec_ff;
      case (sec_ff)
         spfe_pkg::SEC_UNMATCHED: begin
            if (soh_hit && engine_running) begin
               nxt_sec = spfe_pkg::SEC_FAIL_EN; // R7
            end else if (rx_pw && pw_ok) begin
               nxt_sec = spfe_pkg::SEC_MATCHED; // R3
            end
         end
         spfe_pkg::SEC_MATCHED: begin
            if (!mode_en) begin
               nxt_sec = spfe_pkg::SEC_UNMATCHED;
            end else if (soh_hit && engine_running) begin
               nxt_sec = spfe_pkg::SEC_FAIL_EN; // R7
            end else if (rx_pw && !pw_ok) begin
               nxt_sec = spfe_pkg::SEC_UNMATCHED; // R3
            end
         end
         spfe_pkg::SEC_FAIL_EN: begin
            // Password outcome ignored while the engine keeps running
            if (!mode_en || !engine_running) begin
               nxt_sec = spfe_pkg::SEC_UNMATCHED; // R7
            end
         end
         default: begin
            nxt_sec = spfe_pkg::SEC_UNMATCHED;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sec_ff <= spfe_pkg::SEC_UNMATCHED; // R18
      end else begin
         sec_ff <= nxt_sec;
      end
   end

   // ----------------------------------------
   // Status byte, refreshed each loop
   // ----------------------------------------
   logic [7:0] st_ff;
   logic [7:0] nxt_st;
   wire fuel_cont = (sec_ff == spfe_pkg::SEC_MATCHED) || (sec_ff == spfe_pkg::SEC_FAIL_EN); // R9 R18

   always_comb begin
      nxt_st = 8'h00; // R8
      nxt_st[spfe_pkg::ST_FUEL_CONT] = fuel_cont; // R9
      nxt_st[spfe_pkg::ST_DIS_TIMEOUT] = fuel_dis_timeout; // R11
      nxt_st[spfe_pkg::ST_DIS_IGN_OFF] = fuel_dis_ign_off; // R11
      nxt_st[spfe_pkg::ST_AUTO_LEARN] = auto_learn_active; // R10
      nxt_st[spfe_pkg::ST_FAIL_ENABLE] = (sec_ff == spfe_pkg::SEC_FAIL_EN); // R10
      nxt_st[spfe_pkg::ST_LEARN_EN] = learn_enable; // R10
   end

   wire st_change = (nxt_st != st_ff);

   // ----------------------------------------
   // Transmit scheduling
   // ----------------------------------------
   logic resp_pend_ff;
   logic ack_wait_ff;
   logic req_pend_ff;
   logic mode_en_d_ff;
   wire send_st = tick && mode_en && (st_change || resp_pend_ff || ack_wait_ff); // R5 R6 R12
   // Request goes one cycle after the loop tick so it never collides with status
   wire send_req = tick_d_ff && mode_en && req_pend_ff; // R14
   wire mode_rise = mode_en && !mode_en_d_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_ff <= spfe_pkg::ST_RESET;
         resp_pend_ff <= 1'b0;
         ack_wait_ff <= 1'b0;
         req_pend_ff <= 1'b0;
         mode_en_d_ff <= 1'b0;
      end else begin
         if (tick) begin
            st_ff <= nxt_st; // R15
         end
         // Set wins over clear in each pending flag
         resp_pend_ff <= rx_pw || (resp_pend_ff && !send_st && mode_en); // R6
         ack_wait_ff <= send_st || (ack_wait_ff && !rx_ack && mode_en); // R12 R13
         req_pend_ff <= mode_rise || (req_pend_ff && !send_req && mode_en); // R14
         mode_en_d_ff <= mode_en;
      end
   end

   // ----------------------------------------
   // Link output registers
   // ----------------------------------------
   logic tx_valid_ff;
   logic [31:0] tx_hdr_ff;
   logic [15:0] tx_data_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_valid_ff <= 1'b0;
         tx_hdr_ff <= 32'h0000_0000;
         tx_data_ff <= 16'h0000;
      end else begin
         tx_valid_ff <= send_st || send_req;
         if (send_st) begin
            tx_hdr_ff <= spfe_pkg::ST_RPT_HDR;
            tx_data_ff <= {8'h00, nxt_st}; // R8
         end else if (send_req) begin
            tx_hdr_ff <= spfe_pkg::PW_REQ_HDR;
            tx_data_ff <= 16'h0000;
         end
      end
   end

   assign lk.pt_valid = tx_valid_ff;
   assign lk.pt_hdr = tx_hdr_ff;
   assign lk.pt_data = tx_data_ff;

   // ----------------------------------------
   // User outputs
   // ----------------------------------------
   logic fuel_en_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         fuel_en_ff <= 1'b0;
      end else begin
         fuel_en_ff <= fuel_cont; // R3
      end
   end

   assign fuel_enable = fuel_en_ff;
   assign status_byte = st_ff;
   assign soh_fail = soh_hit;

endmodule : spfe_pt_end

// ### testbench/spfe_link_checker.sv
`timescale 1ns/1ps
module spfe_link_checker #(
   parameter int LOOP_CYC = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Platform to powertrain
   input wire logic pf_valid,
   input wire logic [31:0] pf_hdr,
   input wire logic [15:0] pf_data,
   // Powertrain to platform
   input wire logic pt_valid,
   input wire logic [31:0] pt_hdr,
   input wire logic [15:0] pt_data
);
   localparam int MAXW = LOOP_CYC + 1;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Message kinds on the wire
   // ----------------------------------------
   wire st_rpt = pt_valid && pt_hdr == spfe_pkg::ST_RPT_HDR;
   wire pw_req = pt_valid && pt_hdr == spfe_pkg::PW_REQ_HDR;
   wire pw_rpt = pf_valid && pf_hdr[7:0] == 8'h01;
   wire ack = pf_valid && pf_hdr[7:0] == 8'h42;

   a_pt_hdr_known: assert property (pt_valid |-> st_rpt || pw_req)
      else $error("unknown powertrain header");
   a_rsvd_bits_zero: assert property (st_rpt |-> pt_data[15:6] == 10'h000)
      else $error("reserved status bits set");
   a_status_single: assert property (st_rpt |=> !st_rpt)
      else $error("status sent twice in a row");
   a_ack_follows: assert property (st_rpt |-> ##2 (ack && pf_hdr == {spfe_pkg::ST_ACK_HDR[31:16],
      spfe_pkg::PF_SRC_DEFAULT, spfe_pkg::ST_ACK_HDR[7:0]}))
      else $error("status not acknowledged");
   a_pf_hdr_even: assert property (pf_valid |-> !pf_hdr[28])
      else $error("odd platform header");
   a_ack_no_data: assert property (ack |-> pf_data == 16'h0000)
      else $error("acknowledge carries data");
   a_req_answered: assert property (pw_req |-> ##[2:3] pw_rpt)
      else $error("password request unanswered");
   a_status_answers: assert property (pw_rpt |-> ##[1:MAXW] st_rpt)
      else $error("password not answered by status");
   a_pt_hdr_hold: assert property (!pt_valid |-> $stable(pt_hdr))
      else $error("powertrain header moved while idle");
endmodule : spfe_link_checker

// ### testbench/test_security_password_fuel_enable.sv
`timescale 1ns/1ps
module test_security_password_fuel_enable;
   localparam int LC = 16;
   localparam int SL = 3;
   logic clk = 1'b0;
   logic e1 = 1'b0;
   logic [15:0] pw_key = 16'h1234;
   logic [15:0] pw2_key = 16'hffff;
   wire sf1, ss1;
   wire [7:0] sb1;
   int st1 = 0;
   int sp1 = 0;
   logic rst_n = 1'b0;
   logic [1:0] m1 = 2'b00;
   logic [1:0] m2 = 2'b10;
   logic e2 = 1'b0;
   logic le2 = 1'b0;
   logic [3:0] ins = 4'b1010;
   wire fe1, fcs, tt, fe2, sf2;
   wire [7:0] psb, sb2;
   int err_count = 0;
   int total_checks = 0;
   int st2 = 0;
   int pw1 = 0;
   int base;
   int k;

   always #50 clk = ~clk;

   spfe_link_if lk (.clk(clk));
   spfe_link_if lk2 (.clk(clk));
   spfe_pt_end #(.LOOP_CYC(LC), .SOH_LOOPS(SL)) spfe_pt_end_i (.clk(clk), .rst_n(rst_n), .lk(lk),
      .power_mode(m1), .engine_running(e1), .learned_pw(pw_key), .learn_enable(ins[3]),
      .auto_learn_active(ins[2]), .fuel_dis_ign_off(ins[1]), .fuel_dis_timeout(ins[0]),
      .fuel_enable(fe1), .status_byte(sb1), .soh_fail(sf1));
   spfe_pf_end #(.LOOP_CYC(LC), .SOH_LOOPS(SL)) spfe_pf_end_i (.clk(clk), .rst_n(rst_n), .lk(lk),
      .power_mode(m1), .password(pw_key), .fuel_continue_seen(fcs), .status_byte(psb),
      .status_strobe(ss1), .telltale(tt));
   // Second powertrain end faces the bench, which plays a platform that breaks rules
   spfe_pt_end #(.LOOP_CYC(LC), .SOH_LOOPS(SL)) spfe_pt_end_i2 (.clk(clk), .rst_n(rst_n), .lk(lk2),
      .power_mode(m2), .engine_running(e2), .learned_pw(pw2_key), .learn_enable(le2),
      .auto_learn_active(ins[2]), .fuel_dis_ign_off(ins[1]), .fuel_dis_timeout(ins[0]),
      .fuel_enable(fe2), .status_byte(sb2), .soh_fail(sf2));
   spfe_link_checker #(.LOOP_CYC(LC)) spfe_link_checker_i (.clk(clk), .rst_n(rst_n),
      .pf_valid(lk.pf_valid), .pf_hdr(lk.pf_hdr), .pf_data(lk.pf_data),
      .pt_valid(lk.pt_valid), .pt_hdr(lk.pt_hdr), .pt_data(lk.pt_data));

   always @(posedge clk) begin
      if (lk2.pt_valid === 1'b1 && lk2.pt_hdr === spfe_pkg::ST_RPT_HDR) st2 <= st2 + 1;
      if (lk.pf_valid === 1'b1 && lk.pf_hdr[7:0] === 8'h01) pw1 <= pw1 + 1;
      if (lk.pt_valid === 1'b1 && lk.pt_hdr === spfe_pkg::ST_RPT_HDR) st1 <= st1 + 1;
      if (ss1 === 1'b1) sp1 <= sp1 + 1;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic loops(input int n);
      repeat (n * LC) @(posedge clk);
   endtask : loops

   // Released lines show the inverse so stale values cannot pass
   task automatic send(input logic [31:0] hdr, input logic [15:0] data);
      @(posedge clk);
      lk2.pf_valid <= 1'b1;
      lk2.pf_hdr <= hdr;
      lk2.pf_data <= data;
      @(posedge clk);
      lk2.pf_valid <= 1'b0;
      lk2.pf_hdr <= ~hdr;
      lk2.pf_data <= ~data;
   endtask : send

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      lk2.pf_valid = 1'b0;
      lk2.pf_hdr = 32'h0000_0000;
      lk2.pf_data = 16'h0000;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      m1 <= 2'b10;
      for (k = 0; k < 12 * LC && fcs !== 1'b1; k++) @(posedge clk);
      // Timeout counts a mismatch; later steps run on to the single verdict
      if (k == 12 * LC) begin
         err_count++;
      end
      repeat (3) @(posedge clk);
      check(16'(psb), {8'h00, 2'b00, ins[3], 1'b0, ins[2:0], 1'b1});
      check(16'(fe1), 16'h0001);
      base = pw1;
      loops(3);
      check(16'(pw1 - base), 16'h0000);
      loops(2);
      check(16'(tt), 16'h0001);
      check(16'(sf1), 16'h0001);
      check(16'(sb1), 16'h0025);
      check(16'(sp1), 16'(st1));
      $display("test main_pair done");
      check(16'(fe2), 16'h0000);
      send(spfe_pkg::PW_RPT_HDR, 16'hfffe);
      loops(2);
      check(16'(fe2), 16'h0000);
      send({4'h3, spfe_pkg::PW_RPT_HDR[27:0]}, 16'hffff);
      loops(2);
      check(16'(fe2), 16'h0000);
      send(spfe_pkg::PW_RPT_HDR, 16'hffff);
      loops(2);
      check(16'(fe2), 16'h0001);
      check(16'(sb2[0]), 16'h0001);
      $display("test password_filter done");
      m2 <= 2'b01;
      send(spfe_pkg::ST_ACK_HDR, 16'h0000);
      base = st2;
      loops(3);
      check(16'(st2 > base), 16'h0001);
      m2 <= 2'b10;
      // Two acks so a retry launched in the ack cycle is also stopped
      send(spfe_pkg::ST_ACK_HDR, 16'h0000);
      loops(1);
      send(spfe_pkg::ST_ACK_HDR, 16'h0000);
      loops(1);
      base = st2;
      loops(3);
      check(16'(st2 - base), 16'h0000);
      le2 <= 1'b1;
      base = st2;
      loops(2);
      check(16'(sb2[5]), 16'h0001);
      check(16'(st2 > base), 16'h0001);
      $display("test acknowledge done");
      send(spfe_pkg::PW_RPT_HDR, 16'h0000);
      e2 <= 1'b1;
      loops(1);
      check(16'(fe2), 16'h0000);
      for (k = 0; k < 6 * LC && sf2 !== 1'b1; k++) @(posedge clk);
      if (k == 6 * LC) begin
         err_count++;
      end
      loops(1);
      check(16'(fe2), 16'h0001);
      check(16'(sb2[4]), 16'h0001);
      // Flip every copied status input and run the first engine into fail-enable
      ins <= 4'b0101;
      e1 <= 1'b1;
      loops(2);
      check(16'(sb2), 16'h003b);
      check(16'(psb), 16'h001b);
      $display("test health_fallback done");
      print_verdict();
   end
endmodule : test_security_password_fuel_enable
